// >>> testbench/dvm_sink_model.sv
// Far side: sample sink with stall control and the external mute circuit.
// Assumes the bench steers stall just after rising clock edges.
`timescale 1ns/1ps
module dvm_sink_model (
  input wire logic clk_sys, // System clock
  input wire logic stall, // Hold off the sink
  input wire logic out_valid, // Sample held
  input wire logic [23:0] out_sample, // Sample value
  output logic out_ready, // Sink takes sample
  input wire logic mute_ctrl_pin_o, // Pin level
  input wire logic mute_ctrl_pin_oe_n, // Pin enable, low drives
  output logic mute_line // Level seen by the mute circuit
);
  logic [23:0] got[$]; // Samples taken, in order
  logic last_r = 1'b0; // Last driven pin level
  // Sink takes a word whenever not stalled
  assign out_ready = !stall;
  // Record accepted words and the last driven level
  always @(posedge clk_sys)
  begin
    if (out_valid && out_ready)
      got.push_back(out_sample);
    if (!mute_ctrl_pin_oe_n)
      last_r <= mute_ctrl_pin_o;
  end
  // A released pin floats, so show the flipped level rather than a stale one
  assign mute_line = mute_ctrl_pin_oe_n ? ~last_r : mute_ctrl_pin_o;
endmodule // dvm_sink_model

// >>> testbench/dvm_volume_mute_asserts.sv
// Port-level checker for the volume and mute block.
// Assumes one clock domain and the synchronous reset rst.
`timescale 1ns/1ps
module dvm_volume_mute_asserts (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [5:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic out_valid, // Output held
  input wire logic out_ready, // Sink takes
  input wire logic [23:0] out_sample, // Output sample
  input wire logic [2:0] out_chan, // Output channel
  input wire logic [9:0] out_atten, // Output attenuation
  input wire logic sp_clk_err, // Clock error
  input wire logic mute_ctrl_pin_o, // Pin level
  input wire logic mute_ctrl_pin_oe_n, // Pin enable, low drives
  input wire logic [6:0] general_outputs // GPO pins
);
  logic [3:0] ctrl_r; // Shadow of the control register
  logic wr_ctrl; // Control register write
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign wr_ctrl = reg_wr && reg_addr == dvm_pkg::CTRL_OFS;
  // Shadow follows control writes as the block takes them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl_r <= dvm_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= reg_wdata[3:0];
  end
  pd_release_a: assert property (ctrl_r[0] |=> mute_ctrl_pin_oe_n)
    else $error("mute pin driven while powered down");
  pin_drive_a: assert property (wr_ctrl && !reg_wdata[0] |-> ##2 !mute_ctrl_pin_oe_n)
    else $error("mute pin not driven after power-up");
  pin_manual_a: assert property (ctrl_r[1] |=> mute_ctrl_pin_o)
    else $error("manual mute level not on pin");
  pin_clkerr_a: assert property (ctrl_r[3] && sp_clk_err |=> mute_ctrl_pin_o)
    else $error("clock error did not raise mute pin");
  pin_quiet_a: assert property (ctrl_r[3:1] == 3'h0 |=> !mute_ctrl_pin_o)
    else $error("mute pin high with no source enabled");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 6'h3F |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  out_hold_a: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_sample) && $stable(out_atten))
    else $error("stalled output changed");
  bad_chan_a: assert property (out_valid && out_chan > 3'h5 |->
    out_sample == 24'h000000 && out_atten == dvm_pkg::ATT_MAX)
    else $error("unused channel not silenced");
  gpo_static_a: assert property (reg_wr && reg_addr == dvm_pkg::GPO_BASE && !reg_wdata[3]
    |-> ##2 general_outputs[0] == $past(reg_wdata[0], 2))
    else $error("static GPO level wrong");
  cover property (wr_ctrl && !reg_wdata[0]);
  cover property (out_valid && !out_ready);
  cover property (out_valid && out_chan == 3'h6);
endmodule // dvm_volume_mute_asserts
bind dvm_volume_mute dvm_volume_mute_asserts u_asserts (.clk_sys, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .out_valid, .out_ready, .out_sample,
  .out_chan, .out_atten, .sp_clk_err, .mute_ctrl_pin_o, .mute_ctrl_pin_oe_n,
  .general_outputs);

// >>> testbench/dvm_volume_mute_bench.sv
// Self-checking bench for the volume and mute block.
// Assumes the sink model on the sample output and the mute pin.
`timescale 1ns/1ps
module dvm_volume_mute_bench;
  logic clk_sys = 0, rst = 1; // Clock and reset
  logic [5:0] reg_addr = 0; // Register address
  logic [15:0] reg_wdata = 0, reg_rdata; // Register data
  logic reg_wr = 0, reg_rd = 0; // Strobes
  logic in_valid = 0, in_ready, out_valid, out_ready; // Stream handshakes
  logic [23:0] in_sample = 0, out_sample; // Samples
  logic [2:0] in_chan = 0, out_chan; // Channels
  logic sp_clk_err = 0, stall = 1; // Error input, sink stall
  logic pin_o, oe_n, mute_line; // Mute pin
  logic [6:0] general_outputs; // GPO pins
  int n_fail = 0, samples_checked = 0; // Counters
  always #20 clk_sys = ~clk_sys; // 25 MHz
  dvm_volume_mute u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .in_valid, .in_sample, .in_chan, .in_ready, .out_valid, .out_ready,
    .out_sample, .out_chan, .out_atten(), .sp_clk_err, .mute_ctrl_pin_o(pin_o),
    .mute_ctrl_pin_oe_n(oe_n), .general_outputs);
  dvm_sink_model u_sink (.clk_sys, .stall, .out_valid, .out_sample, .out_ready,
    .mute_ctrl_pin_o(pin_o), .mute_ctrl_pin_oe_n(oe_n), .mute_line);
  // Compare one value and count it
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  // Let a control write reach the pin, then compare enable and level
  task automatic pin(input logic e);
    repeat (2) @(posedge clk_sys);
    #1 chk({oe_n, mute_line}, {1'b0, e});
  endtask
  // Offer one sample until the FIFO takes it
  task automatic push(input logic [2:0] c, input logic [23:0] s);
    @(posedge clk_sys);
    in_chan <= c;
    in_sample <= s;
    in_valid <= 1'b1;
    do @(posedge clk_sys); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask
  // Print counts and verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish;
  end
  // Main sequence
  initial
  begin
    logic [15:0] v;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(oe_n, 1);
    rdchk(dvm_pkg::CTRL_OFS, 16'h0001);
    rdchk(dvm_pkg::RAMP_OFS, 16'h0001);
    rdchk(dvm_pkg::ATAPI_BASE, 16'h0005);
    rdchk(6'h3F, 16'h0000);
    rdchk(dvm_pkg::STAT_OFS, 16'h01F9);
    $display("test reset done");
    wr(dvm_pkg::RAMP_OFS, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      wr(dvm_pkg::VOL_BASE + 6'(i), 16'(i * 20 + 1));
      rdchk(dvm_pkg::ATT_BASE + 6'(i), 16'(i * 80 + 4));
    end
    wr(dvm_pkg::VOL_BASE, 16'h00FF);
    rdchk(dvm_pkg::ATT_BASE, 16'h03F8);
    wr(dvm_pkg::RAMP_OFS, 16'h0001);
    wr(dvm_pkg::VOL_BASE, 16'h00FC);
    rd(dvm_pkg::ATT_BASE, v);
    chk(v >= 16'h03F6, 1);
    repeat (300) @(posedge clk_sys);
    rdchk(dvm_pkg::ATT_BASE, 16'h03F0);
    repeat (100) @(posedge clk_sys);
    rdchk(dvm_pkg::ATT_BASE, 16'h03F0);
    wr(dvm_pkg::RAMP_OFS, 16'h0000);
    wr(dvm_pkg::MUTE_OFS, 16'h0004);
    wr(dvm_pkg::GPO_BASE + 6'h01, 16'h000A);
    wr(dvm_pkg::GPO_BASE, 16'h0001);
    rdchk(dvm_pkg::ATT_BASE + 6'h02, 16'h03F8);
    rdchk(dvm_pkg::ATT_BASE + 6'h03, 16'h00F4);
    chk(general_outputs, 7'h03);
    wr(dvm_pkg::MUTE_OFS, 16'h0000);
    rdchk(dvm_pkg::ATT_BASE + 6'h02, 16'h00A4);
    chk(general_outputs, 7'h01);
    wr(dvm_pkg::RAMP_OFS, 16'h0001);
    wr(dvm_pkg::MUTE_OFS, 16'h0008);
    rd(dvm_pkg::ATT_BASE + 6'h03, v);
    chk(v <= 16'h00F6, 1);
    $display("test volume and mute done");
    wr(dvm_pkg::MUTE_OFS, 16'h003F);
    wr(dvm_pkg::CTRL_OFS, 16'h0000);
    pin(0);
    wr(dvm_pkg::CTRL_OFS, 16'h0002);
    pin(1);
    @(posedge clk_sys) sp_clk_err <= 1'b1;
    wr(dvm_pkg::CTRL_OFS, 16'h0008);
    pin(1);
    @(posedge clk_sys) sp_clk_err <= 1'b0;
    pin(0);
    wr(dvm_pkg::CTRL_OFS, 16'h0004);
    pin(1);
    wr(dvm_pkg::CTRL_OFS, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 chk(oe_n, 1);
    $display("test mute pin done");
    wr(dvm_pkg::ATAPI_BASE, 16'h000E);
    push(3'h1, 24'h000300);
    push(3'h0, 24'h000100);
    push(3'h6, 24'h000123);
    for (int k = 1; k <= 14; k++)
      push(3'h5, 24'(k));
    @(posedge clk_sys);
    #1 chk(in_ready, 0);
    @(posedge clk_sys) stall <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(24'(u_sink.got.size()), 24'd17);
    for (int k = 0; k < 17; k++)
      chk(u_sink.got[k], k == 0 ? 24'h000180 : k == 1 ? 24'h000300 : 24'(k > 2 ? k - 2 : 0));
    $display("test stream done");
    tally_and_finish;
  end
endmodule // dvm_volume_mute_bench

// >>> verilog/dvm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dvm_fifo #(
  parameter int W = 8,      // Word width
  parameter int DEPTH = 16  // Number of words, power of two
) (
  input wire logic clk_sys,  // System clock
  input wire logic rst,      // Synchronous reset
  dvm_fifo_if.fifo f         // Write and read sides
);

  localparam int PW = $clog2(DEPTH);  // Pointer width

  logic [W-1:0] mem [DEPTH];  // Word storage
  logic [PW-1:0] wptr_r;      // Next write slot
  logic [PW-1:0] rptr_r;      // Head slot
  logic [PW:0] cnt_r;         // Words held
  logic push;                 // Word accepted
  logic pop;                  // Word removed

  // Honest flags from the occupancy count
  assign f.wready = (cnt_r != (PW+1)'(DEPTH));
  assign f.rvalid = (cnt_r != '0);
  assign f.rdata = mem[rptr_r];
  assign push = f.wvalid && f.wready;
  assign pop = f.rvalid && f.rready;

  // Storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wptr_r] <= f.wdata;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop)
      begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // dvm_fifo

// >>> verilog/dvm_fifo_if.sv
// Valid/ready carrier between the block and its sample FIFO.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface dvm_fifo_if #(parameter int W = 8);
  logic wvalid;          // Write side offers a word
  logic wready;          // FIFO can take a word
  logic [W-1:0] wdata;   // Word written
  logic rvalid;          // FIFO holds a word
  logic rready;          // Reader takes the head word
  logic [W-1:0] rdata;   // Head word

  modport src (output wvalid, output wdata, input wready);
  modport fifo (input wvalid, input wdata, output wready,
                output rvalid, output rdata, input rready);
  modport snk (input rvalid, input rdata, output rready);
endinterface // dvm_fifo_if

// >>> verilog/dvm_pkg.sv
// Constants shared by the volume and mute block and its sample FIFO.
// Assumes a single 25 MHz system clock and a 6-bit register address space.
package dvm_pkg;

  // Channel counts and widths
  localparam int NCH = 6;                   // DAC channels
  localparam int NPAIR = 3;                 // A-B channel pairs
  localparam int NGPO = 7;                  // General purpose outputs
  localparam int SAMPLE_W = 24;             // Sample width
  localparam int CH_W = 3;                  // Channel index width
  localparam int ATT_W = 10;                // Applied attenuation, 0.125 dB units
  localparam int VOL_W = 8;                 // Volume setting, 0.5 dB units
  localparam int ADDR_W = 6;                // Register address width
  localparam int DATA_W = 16;               // Register data width
  localparam int FIFO_W = SAMPLE_W + CH_W;  // FIFO word: channel and sample
  localparam int FIFO_DEPTH = 16;           // FIFO depth in words

  // Attenuation scale
  localparam logic [VOL_W-1:0] VOL_MAX = 8'hFE;   // 127 dB in 0.5 dB steps
  localparam logic [ATT_W-1:0] ATT_MAX = 10'h3F8; // 127 dB in 0.125 dB steps

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 6'h00;    // Power and mute pin control
  localparam logic [ADDR_W-1:0] RAMP_OFS = 6'h01;    // Ramp rate selection
  localparam logic [ADDR_W-1:0] MUTE_OFS = 6'h02;    // Channel mute bits
  localparam logic [ADDR_W-1:0] STAT_OFS = 6'h03;    // Status, read only
  localparam logic [ADDR_W-1:0] VOL_BASE = 6'h08;    // Volume, one per channel
  localparam logic [ADDR_W-1:0] ATAPI_BASE = 6'h10;  // Mixing, one per pair
  localparam logic [ADDR_W-1:0] GPO_BASE = 6'h18;    // GPO function, one per pin
  localparam logic [ADDR_W-1:0] ATT_BASE = 6'h20;    // Applied attenuation, read only

  // Control register fields
  localparam int CTRL_PDN_BIT = 0;   // Power-down bit
  localparam int CTRL_MAN_BIT = 1;   // Manual mute pin level
  localparam int CTRL_AZ_BIT = 2;    // Auto assert on all-zero data
  localparam int CTRL_CE_BIT = 3;    // Auto assert on serial clock error

  // Status register fields
  localparam int STAT_ZERO_BIT = 0;  // All channels carry zero samples
  localparam int STAT_CERR_BIT = 1;  // Serial clock error present
  localparam int STAT_PIN_BIT = 2;   // Mute pin level
  localparam int STAT_TGT_LSB = 3;   // Per-channel at-target flags

  // GPO function field
  localparam int GPO_MUTE_BIT = 3;   // 1: hardware mute output, 0: static level

  // ATAPI source codes
  localparam logic [1:0] SRC_MUTE = 2'h0;  // Silence
  localparam logic [1:0] SRC_OWN = 2'h1;   // Own channel
  localparam logic [1:0] SRC_PART = 2'h2;  // Partner channel
  localparam logic [1:0] SRC_AVG = 2'h3;   // Average of both

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h1;         // Powered down at power-up
  localparam logic [1:0] RAMP_RST = 2'h1;         // Fastest ramp; select 0 is ramp off
  localparam logic [NCH-1:0] MUTE_RST = 6'h00;    // No channel muted
  localparam logic [VOL_W-1:0] VOL_RST = 8'h00;   // 0 dB
  localparam logic [3:0] ATAPI_RST = 4'h5;        // A from A, B from B
  localparam logic [3:0] GPO_RST = 4'h0;          // Drive low

  // Ramp tick timing
  localparam int CLK_NS = 40;                      // System clock period
  localparam int RAMP1_NS = 1000;                  // Tick period, select 1
  localparam int RAMP2_NS = 8000;                  // Tick period, select 2
  localparam int RAMP3_NS = 64000;                 // Tick period, select 3
  localparam int RAMP1_CYC = (RAMP1_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP2_CYC = (RAMP2_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP3_CYC = (RAMP3_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 11;                      // Tick counter width

endpackage

// >>> verilog/dvm_volume_mute.sv
// Six-channel digital volume, soft mute, mute pin and GPO mute logic.
// Assumes synchronous inputs on clk_sys and a register master that never waits.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps

// Function
// - Per-channel attenuation 0 to 127 dB, 0.5 dB
// - Volume changes ramp 0.125 dB at selected rate
// - Separate mute bit for each channel
// - Muted channel goes to maximum attenuation
// - Unmuted channel returns to volume setting
// - Mute entry and exit ramp, not jump
// - Mute pin high impedance while powered down
// - Host sets mute pin level after power-up
// - Mute pin auto high on all-zero data
// - Mute pin auto high on clock error
// - GPOs configurable as per-circuit mute outputs
// - ATAPI mixing applied per A-B pair
module dvm_volume_mute (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [dvm_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [dvm_pkg::DATA_W-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [dvm_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
  input wire logic in_valid, // Sample offered
  input wire logic [dvm_pkg::SAMPLE_W-1:0] in_sample, // Input sample
  input wire logic [dvm_pkg::CH_W-1:0] in_chan, // Input channel
  output logic in_ready, // FIFO has room
  output logic out_valid, // Output sample held
  input wire logic out_ready, // Sink takes sample
  output logic [dvm_pkg::SAMPLE_W-1:0] out_sample, // Mixed sample
  output logic [dvm_pkg::CH_W-1:0] out_chan, // Output channel
  output logic [dvm_pkg::ATT_W-1:0] out_atten, // Attenuation to apply
  input wire logic sp_clk_err, // Serial clock error
  output logic mute_ctrl_pin_o, // Mute pin level
  output logic mute_ctrl_pin_oe_n, // Mute pin enable, low drives
  output logic [dvm_pkg::NGPO-1:0] general_outputs // GPO pins
);

  // Control registers
  logic pdn_r; // Power-down bit
  logic man_r; // Manual pin level
  logic az_en_r; // All-zero auto enable
  logic ce_en_r; // Clock error auto enable
  logic [1:0] ramp_rate_sel_r; // Ramp rate selection
  logic [dvm_pkg::NCH-1:0] channel_mute_bit_r; // Per-channel mute
  logic [dvm_pkg::VOL_W-1:0] vol_r [dvm_pkg::NCH]; // Volume settings
  logic [3:0] atapi_r [dvm_pkg::NPAIR]; // Pair mixing codes
  logic [3:0] gpo_r [dvm_pkg::NGPO]; // GPO functions

  // Datapath state
  logic [dvm_pkg::ATT_W-1:0] att_r [dvm_pkg::NCH]; // Applied attenuation
  logic [dvm_pkg::SAMPLE_W-1:0] lat_r [dvm_pkg::NCH]; // Latest sample per channel
  logic [dvm_pkg::TICK_W-1:0] tick_cnt_r; // Ramp tick divider
  logic tick; // Ramp step strobe
  logic all_zero; // Every channel at zero
  logic [dvm_pkg::NCH-1:0] at_tgt; // Channel reached target
  logic [dvm_pkg::NCH-1:0] at_max; // Channel fully attenuated
  logic pop; // Sample taken from FIFO
  logic [dvm_pkg::CH_W-1:0] pch; // Popped channel
  logic [dvm_pkg::SAMPLE_W-1:0] psmp; // Popped sample

  dvm_fifo_if #(.W(dvm_pkg::FIFO_W)) fq ();  // Sample queue carrier

  // Tick period for a ramp rate selection
  function automatic logic [dvm_pkg::TICK_W-1:0] ramp_period(input logic [1:0] sel);
    case (sel)
      2'h1: ramp_period = dvm_pkg::TICK_W'(dvm_pkg::RAMP1_CYC);
      2'h2: ramp_period = dvm_pkg::TICK_W'(dvm_pkg::RAMP2_CYC);
      2'h3: ramp_period = dvm_pkg::TICK_W'(dvm_pkg::RAMP3_CYC);
      default: ramp_period = dvm_pkg::TICK_W'(1);
    endcase
  endfunction

  // Target attenuation of a channel in 0.125 dB units
  function automatic logic [dvm_pkg::ATT_W-1:0] target_att(input logic mute,
                                                           input logic [7:0] vol);
    logic [7:0] v;
    v = (vol > dvm_pkg::VOL_MAX) ? dvm_pkg::VOL_MAX : vol;  // Clamp to 127 dB
    if (mute)
    begin
      target_att = dvm_pkg::ATT_MAX;  // Mute forces full attenuation
    end
    else
    begin
      target_att = {v, 2'h0};  // Volume setting, four steps per 0.5 dB
    end
  endfunction

  // Pick a mixed sample from own and partner samples
  function automatic logic [dvm_pkg::SAMPLE_W-1:0] mix(input logic [1:0] src,
    input logic [dvm_pkg::SAMPLE_W-1:0] own, input logic [dvm_pkg::SAMPLE_W-1:0] part);
    logic [dvm_pkg::SAMPLE_W:0] sum;
    sum = {own[dvm_pkg::SAMPLE_W-1], own} + {part[dvm_pkg::SAMPLE_W-1], part};
    case (src)
      dvm_pkg::SRC_MUTE: mix = '0;
      dvm_pkg::SRC_OWN: mix = own;
      dvm_pkg::SRC_PART: mix = part;
      dvm_pkg::SRC_AVG: mix = sum[dvm_pkg::SAMPLE_W:1];
      default: mix = own;
    endcase
  endfunction

  // Sample queue in front of the mixer
  dvm_fifo #(.W(dvm_pkg::FIFO_W), .DEPTH(dvm_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .f(fq.fifo)
  );

  assign fq.wvalid = in_valid;
  assign fq.wdata = {in_chan, in_sample};
  assign in_ready = fq.wready;
  assign pop = fq.rvalid && (!out_valid || out_ready);
  assign fq.rready = (!out_valid || out_ready);
  assign pch = fq.rdata[dvm_pkg::FIFO_W-1 -: dvm_pkg::CH_W];
  assign psmp = fq.rdata[dvm_pkg::SAMPLE_W-1:0];

  // Register writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      {ce_en_r, az_en_r, man_r, pdn_r} <= dvm_pkg::CTRL_RST;
      ramp_rate_sel_r <= dvm_pkg::RAMP_RST;
      channel_mute_bit_r <= dvm_pkg::MUTE_RST;
      for (int i = 0; i < dvm_pkg::NCH; i++) vol_r[i] <= dvm_pkg::VOL_RST;
      for (int i = 0; i < dvm_pkg::NPAIR; i++) atapi_r[i] <= dvm_pkg::ATAPI_RST;
      for (int i = 0; i < dvm_pkg::NGPO; i++) gpo_r[i] <= dvm_pkg::GPO_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == dvm_pkg::CTRL_OFS)
      begin
        pdn_r <= reg_wdata[dvm_pkg::CTRL_PDN_BIT];
        man_r <= reg_wdata[dvm_pkg::CTRL_MAN_BIT];
        az_en_r <= reg_wdata[dvm_pkg::CTRL_AZ_BIT];
        ce_en_r <= reg_wdata[dvm_pkg::CTRL_CE_BIT];
      end
      if (reg_addr == dvm_pkg::RAMP_OFS)
      begin
        ramp_rate_sel_r <= reg_wdata[1:0];
      end
      if (reg_addr == dvm_pkg::MUTE_OFS)
      begin
        channel_mute_bit_r <= reg_wdata[dvm_pkg::NCH-1:0];  // One bit per channel
      end
      for (int i = 0; i < dvm_pkg::NCH; i++)
      begin
        if (reg_addr == dvm_pkg::VOL_BASE + dvm_pkg::ADDR_W'(i))
        begin
          vol_r[i] <= reg_wdata[dvm_pkg::VOL_W-1:0];
        end
      end
      for (int i = 0; i < dvm_pkg::NPAIR; i++)
      begin
        if (reg_addr == dvm_pkg::ATAPI_BASE + dvm_pkg::ADDR_W'(i))
        begin
          atapi_r[i] <= reg_wdata[3:0];
        end
      end
      for (int i = 0; i < dvm_pkg::NGPO; i++)
      begin
        if (reg_addr == dvm_pkg::GPO_BASE + dvm_pkg::ADDR_W'(i))
        begin
          gpo_r[i] <= reg_wdata[3:0];
        end
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= '0;  // Unmapped addresses read zero
      if (reg_addr == dvm_pkg::CTRL_OFS)
      begin
        reg_rdata[3:0] <= {ce_en_r, az_en_r, man_r, pdn_r};
      end
      if (reg_addr == dvm_pkg::RAMP_OFS)
      begin
        reg_rdata[1:0] <= ramp_rate_sel_r;
      end
      if (reg_addr == dvm_pkg::MUTE_OFS)
      begin
        reg_rdata[dvm_pkg::NCH-1:0] <= channel_mute_bit_r;
      end
      if (reg_addr == dvm_pkg::STAT_OFS)
      begin
        reg_rdata[dvm_pkg::STAT_ZERO_BIT] <= all_zero;
        reg_rdata[dvm_pkg::STAT_CERR_BIT] <= sp_clk_err;
        reg_rdata[dvm_pkg::STAT_PIN_BIT] <= mute_ctrl_pin_o;
        reg_rdata[dvm_pkg::STAT_TGT_LSB +: dvm_pkg::NCH] <= at_tgt;
      end
      for (int i = 0; i < dvm_pkg::NCH; i++)
      begin
        if (reg_addr == dvm_pkg::VOL_BASE + dvm_pkg::ADDR_W'(i))
        begin
          reg_rdata[dvm_pkg::VOL_W-1:0] <= vol_r[i];
        end
        if (reg_addr == dvm_pkg::ATT_BASE + dvm_pkg::ADDR_W'(i))
        begin
          reg_rdata[dvm_pkg::ATT_W-1:0] <= att_r[i];
        end
      end
      for (int i = 0; i < dvm_pkg::NPAIR; i++)
      begin
        if (reg_addr == dvm_pkg::ATAPI_BASE + dvm_pkg::ADDR_W'(i))
        begin
          reg_rdata[3:0] <= atapi_r[i];
        end
      end
      for (int i = 0; i < dvm_pkg::NGPO; i++)
      begin
        if (reg_addr == dvm_pkg::GPO_BASE + dvm_pkg::ADDR_W'(i))
        begin
          reg_rdata[3:0] <= gpo_r[i];
        end
      end
    end
  end

  // Ramp tick divider, restarts only after a tick, not on a rate change
  assign tick = (tick_cnt_r >= ramp_period(ramp_rate_sel_r) - 1'b1);
  always_ff @(posedge clk_sys)
  begin
    if (rst || tick)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 1'b1;  // Sets the ramp rate
    end
  end

  // Per-channel target and limit flags
  always_comb
  begin
    for (int i = 0; i < dvm_pkg::NCH; i++)
    begin
      at_tgt[i] = (att_r[i] == target_att(channel_mute_bit_r[i], vol_r[i]));
      at_max[i] = (att_r[i] == dvm_pkg::ATT_MAX);
    end
  end

  // Applied attenuation: jump when ramping is off, else step per tick
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < dvm_pkg::NCH; i++) att_r[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < dvm_pkg::NCH; i++)
      begin
        if (ramp_rate_sel_r == 2'h0)
        begin
          att_r[i] <= target_att(channel_mute_bit_r[i], vol_r[i]);
        end
        else if (tick && !at_tgt[i])
        begin
          // One 0.125 dB step toward target, in and out of mute alike
          if (att_r[i] < target_att(channel_mute_bit_r[i], vol_r[i]))
          begin
            att_r[i] <= att_r[i] + 1'b1;
          end
          else
          begin
            att_r[i] <= att_r[i] - 1'b1;
          end
        end
      end
    end
  end

  // Latest sample store and zero detection
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < dvm_pkg::NCH; i++) lat_r[i] <= '0;
    end
    else if (pop && (pch < dvm_pkg::CH_W'(dvm_pkg::NCH)))
    begin
      lat_r[pch] <= psmp;
    end
  end

  always_comb
  begin
    all_zero = 1'b1;
    for (int i = 0; i < dvm_pkg::NCH; i++)
    begin
      if (lat_r[i] != '0)
      begin
        all_zero = 1'b0;
      end
    end
  end

  // Output stage: pair mixing and attenuation tag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_sample <= '0;
      out_chan <= '0;
      out_atten <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_chan <= pch;
      if (pch < dvm_pkg::CH_W'(dvm_pkg::NCH))
      begin
        // Even channel is A, odd is B; pair code halves select the source
        out_sample <= mix(pch[0] ? atapi_r[pch[2:1]][3:2] : atapi_r[pch[2:1]][1:0],
                          psmp, lat_r[pch ^ 3'h1]);
        out_atten <= att_r[pch];
      end
      else
      begin
        out_sample <= '0;  // Channel outside range is silenced
        out_atten <= dvm_pkg::ATT_MAX;
      end
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

  // Mute control pin; host mutes channels first to avoid transients
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mute_ctrl_pin_o <= 1'b0;
      mute_ctrl_pin_oe_n <= 1'b1;  // Released during power-up
    end
    else
    begin
      mute_ctrl_pin_oe_n <= pdn_r;  // Released while powered down
      mute_ctrl_pin_o <= man_r  // Host-driven level
                         || (az_en_r && all_zero)
                         || (ce_en_r && sp_clk_err);
    end
  end

  // General purpose outputs: static level or per-circuit mute signal
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      general_outputs <= '0;
    end
    else
    begin
      for (int i = 0; i < dvm_pkg::NGPO; i++)
      begin
        if (!gpo_r[i][dvm_pkg::GPO_MUTE_BIT])
        begin
          general_outputs[i] <= gpo_r[i][0];
        end
        else if (gpo_r[i][2:0] < dvm_pkg::CH_W'(dvm_pkg::NCH))
        begin
          general_outputs[i] <= at_max[gpo_r[i][2:0]];  // One channel muted
        end
        else
        begin
          general_outputs[i] <= &at_max;  // Every channel muted
        end
      end
    end
  end

endmodule // dvm_volume_mute
